// >>> rtl/acc_defs.vh
// register offsets, field positions, codes and timing counts for the conversion control block
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
`define ACC_ADDR_W        3
`define ACC_OFF_CONTROL   3'h0
`define ACC_OFF_CONFIG    3'h1
`define ACC_OFF_TRIGGER   3'h2
`define ACC_OFF_RES_UPPER 3'h3
`define ACC_OFF_RES_LOWER 3'h4
`define ACC_OFF_STATUS    3'h5
`define ACC_CTL_ON        0
`define ACC_CTL_GO        1
`define ACC_CTL_CH_LO     2
`define ACC_CTL_CH_HI     6
`define ACC_CFG_JUST      7
`define ACC_CFG_CLK_LO    4
`define ACC_CFG_CLK_HI    6
`define ACC_CFG_REF_LO    0
`define ACC_CFG_REF_HI    1
`define ACC_TRG_LO        4
`define ACC_TRG_HI        7
`define ACC_STS_DONE      0
`define ACC_STS_TMRA      1
`define ACC_STS_TMRB      2
`define ACC_RESET_BYTE    8'h00
`define ACC_CH_EXT_MAX    5'h03
`define ACC_CH_TEMP       5'h1D
`define ACC_CH_DAC        5'h1E
`define ACC_CH_FIXREF     5'h1F
`define ACC_REF_SUPPLY    2'h0
`define ACC_REF_EXT       2'h2
`define ACC_REF_FIXED     2'h3
`define ACC_TRG_NONE      4'h0
`define ACC_TRG_PWM1_IRQ  4'h1
`define ACC_TRG_PWM2_IRQ  4'h2
`define ACC_TRG_TMRA      4'h3
`define ACC_TRG_TMRB      4'h4
`define ACC_TRG_TMRC      4'h5
`define ACC_TRG_COMP      4'h6
`define ACC_TRG_PWM3_IRQ  4'h7
`define ACC_TRG_PWM1_OFS  4'h8
`define ACC_TRG_PWM2_OFS  4'h9
`define ACC_TRG_PWM3_OFS  4'hA
`define ACC_RES_BITS      10
`define ACC_HALF_PERIODS  5'h17
`endif

// >>> rtl/acc_clock_divider.v
// bit-clock tick generator: divided system clock or synchronised rc clock
`timescale 1ns/1ps
`default_nettype none
module acc_clock_divider
(
   input  wire       CLK,
   input  wire       RST,
   input  wire       run,
   input  wire [2:0] clk_sel,
   input  wire       rc_clk,
   output reg        half_tick
);
   reg  [5:0] cnt_q;
   reg  [5:0] limit;
   reg        rc_s1_q;
   reg        rc_s2_q;
   reg        rc_s3_q;
   wire       use_rc;

   assign use_rc = (clk_sel[1:0] == 2'h3);

   // half a bit period per tick, so a /2 clock ticks every cycle
   always @*
   begin
      case (clk_sel)
         3'h0:    limit = 6'h00;
         3'h4:    limit = 6'h01;
         3'h1:    limit = 6'h03;
         3'h5:    limit = 6'h07;
         3'h2:    limit = 6'h0F;
         3'h6:    limit = 6'h1F;
         default: limit = 6'h00;
      endcase
   end

   always @(posedge CLK)
   begin
      if (RST)
      begin
         cnt_q     <= 6'h00;
         rc_s1_q   <= 1'b0;
         rc_s2_q   <= 1'b0;
         rc_s3_q   <= 1'b0;
         half_tick <= 1'b0;
      end
      else
      begin
         rc_s1_q <= rc_clk;
         rc_s2_q <= rc_s1_q;
         rc_s3_q <= rc_s2_q;
         if (!run)
         begin
            cnt_q     <= 6'h00;
            half_tick <= 1'b0;
         end
         else if (use_rc)
         begin
            // each rc edge is half a bit period
            half_tick <= rc_s2_q ^ rc_s3_q;
         end
         else if (cnt_q >= limit)
         begin
            cnt_q     <= 6'h00;
            half_tick <= 1'b1;
         end
         else
         begin
            cnt_q     <= cnt_q + 6'h01;
            half_tick <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/acc_conv_control.v
// conversion control, sequencing and result formatting for a 10-bit sar converter
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"
module acc_conv_control
(
   input  wire       CLK,
   input  wire       RST,
   input  wire [2:0] ADDR,
   input  wire [7:0] WDATA,
   input  wire       WR,
   input  wire       RD,
   output reg  [7:0] RDATA,
   input  wire       COMPARE_HIGH,
   input  wire       RC_CONV_CLOCK,
   input  wire       TMR_A_OVERFLOW,
   input  wire       TMR_B_OVERFLOW,
   input  wire       TMR_C_MATCH,
   input  wire       COMP_OUT_SYNCED,
   input  wire [2:0] PWM_INTERRUPT,
   input  wire [2:0] PWM_OFFSET_MATCH,
   output reg  [9:0] DAC_CODE,
   output reg        SAMPLE_HOLD,
   output reg        ANALOG_POWER,
   output reg  [3:0] INPUT_ROUTE,
   output reg  [1:0] POSREF_ROUTE,
   output reg        TMR_A_FLAG,
   output reg        TMR_B_FLAG,
   output reg        CONV_DONE_FLAG
);
   localparam ST_IDLE = 2'h0;
   localparam ST_CONV = 2'h1;

   reg  [4:0] chan_q;
   reg        on_q;
   reg        go_q;
   reg        just_q;
   reg  [2:0] clksel_q;
   reg  [1:0] ref_q;
   reg  [3:0] trig_q;
   reg  [7:0] res_up_q;
   reg  [7:0] res_lo_q;
   reg  [1:0] state_q;
   reg  [4:0] half_q;
   reg  [9:0] sar_q;
   reg  [3:0] bit_q;
   reg        trig_prev_q;
   reg        trig_now;
   reg        lsb_done_q;
   reg  [9:0] abort_value;
   wire       half_tick;
   wire       wr_ctl;
   wire       sw_abort;
   wire       trig_rise;
   wire       start;
   wire       abort;

   acc_clock_divider acc_clock_divider_inst
   (
      .CLK       (CLK),
      .RST       (RST),
      .run       (state_q == ST_CONV),
      .clk_sel   (clksel_q),
      .rc_clk    (RC_CONV_CLOCK),
      .half_tick (half_tick)
   );

   // fills bits below the last resolved one with that bit's value
   function [9:0] fill_partial;
      input [9:0] v;
      input [3:0] nxt;
      integer i;
      begin
         fill_partial = v;
         for (i = 0; i < 10; i = i + 1)
            if (i < nxt)
               fill_partial[i] = v[nxt];
      end
   endfunction

   // places a 10-bit value into the two result bytes
   function [15:0] justify;
      input [9:0] v;
      input       right;
      begin
         if (right)
            justify = {6'h00, v};
         else
            justify = {v, 6'h00};
      end
   endfunction

   // early stop keeps resolved bits, the rest copy the last one resolved;
   // with nothing resolved yet the result is taken as zero
   always @*
   begin
      if (lsb_done_q)
         abort_value = sar_q;
      else if (bit_q == 4'h9)
         abort_value = 10'h000;
      else
         abort_value = fill_partial(sar_q, bit_q + 4'h1);
   end

   // codes outside the table give no trigger at all
   always @*
   begin
      case (trig_q)
         `ACC_TRG_PWM1_IRQ: trig_now = PWM_INTERRUPT[0];
         `ACC_TRG_PWM2_IRQ: trig_now = PWM_INTERRUPT[1];
         `ACC_TRG_PWM3_IRQ: trig_now = PWM_INTERRUPT[2];
         `ACC_TRG_TMRA:     trig_now = TMR_A_OVERFLOW;
         `ACC_TRG_TMRB:     trig_now = TMR_B_OVERFLOW;
         `ACC_TRG_TMRC:     trig_now = TMR_C_MATCH;
         `ACC_TRG_COMP:     trig_now = COMP_OUT_SYNCED;
         `ACC_TRG_PWM1_OFS: trig_now = PWM_OFFSET_MATCH[0];
         `ACC_TRG_PWM2_OFS: trig_now = PWM_OFFSET_MATCH[1];
         `ACC_TRG_PWM3_OFS: trig_now = PWM_OFFSET_MATCH[2];
         default:           trig_now = 1'b0;
      endcase
   end

   always @*
   begin
      if (chan_q <= `ACC_CH_EXT_MAX)
         INPUT_ROUTE = {2'h0, chan_q[1:0]} + 4'h1;
      else if (chan_q == `ACC_CH_TEMP)
         INPUT_ROUTE = 4'h5;
      else if (chan_q == `ACC_CH_DAC)
         INPUT_ROUTE = 4'h6;
      else if (chan_q == `ACC_CH_FIXREF)
         INPUT_ROUTE = 4'h7;
      else
         INPUT_ROUTE = 4'h0;
      // no input is routed while the converter is off
      if (!on_q)
         INPUT_ROUTE = 4'h0;
      POSREF_ROUTE = ref_q;
      ANALOG_POWER = on_q;
   end

   // control writes drive both the start and the early stop
   assign wr_ctl    = WR && (ADDR == `ACC_OFF_CONTROL);
   assign trig_rise = trig_now && !trig_prev_q;
   assign sw_abort  = wr_ctl && !WDATA[`ACC_CTL_GO] && (state_q == ST_CONV);
   // trigger only counts with the converter on, else nothing samples
   assign start     = on_q && (state_q == ST_IDLE) &&
                      ((wr_ctl && WDATA[`ACC_CTL_GO] && WDATA[`ACC_CTL_ON]) || trig_rise);
   // a go-clear or a power-off write stops a running conversion early
   assign abort     = (state_q == ST_CONV) &&
                      (sw_abort || !on_q || (wr_ctl && !WDATA[`ACC_CTL_ON]));

   always @(posedge CLK)
   begin
      if (RST)
      begin
         chan_q         <= 5'h00;
         on_q           <= 1'b0;
         go_q           <= 1'b0;
         just_q         <= 1'b0;
         clksel_q       <= 3'h0;
         ref_q          <= 2'h0;
         trig_q         <= 4'h0;
         res_up_q       <= 8'h00;
         res_lo_q       <= 8'h00;
         state_q        <= ST_IDLE;
         half_q         <= 5'h00;
         sar_q          <= 10'h000;
         bit_q          <= 4'h9;
         lsb_done_q     <= 1'b0;
         trig_prev_q    <= 1'b0;
         TMR_A_FLAG     <= 1'b0;
         TMR_B_FLAG     <= 1'b0;
         CONV_DONE_FLAG <= 1'b0;
         SAMPLE_HOLD    <= 1'b1;
         DAC_CODE       <= 10'h000;
         RDATA          <= 8'h00;
      end
      else
      begin
         trig_prev_q <= trig_now;
         // read data stand only in the cycle after the strobe
         RDATA <= 8'h00;
         if (RD)
         begin
            case (ADDR)
               `ACC_OFF_CONTROL:   RDATA <= {1'b0, chan_q, go_q, on_q};
               `ACC_OFF_CONFIG:    RDATA <= {just_q, clksel_q, 2'h0, ref_q};
               `ACC_OFF_TRIGGER:   RDATA <= {trig_q, 4'h0};
               `ACC_OFF_RES_UPPER: RDATA <= res_up_q;
               `ACC_OFF_RES_LOWER: RDATA <= res_lo_q;
               `ACC_OFF_STATUS:    RDATA <= {5'h00, TMR_B_FLAG, TMR_A_FLAG, CONV_DONE_FLAG};
               default:            RDATA <= 8'h00;
            endcase
         end
         if (WR)
         begin
            case (ADDR)
               `ACC_OFF_CONTROL:
               begin
                  chan_q <= WDATA[`ACC_CTL_CH_HI:`ACC_CTL_CH_LO];
                  on_q   <= WDATA[`ACC_CTL_ON];
               end
               `ACC_OFF_CONFIG:
               begin
                  just_q   <= WDATA[`ACC_CFG_JUST];
                  clksel_q <= WDATA[`ACC_CFG_CLK_HI:`ACC_CFG_CLK_LO];
                  ref_q    <= WDATA[`ACC_CFG_REF_HI:`ACC_CFG_REF_LO];
               end
               `ACC_OFF_TRIGGER:   trig_q <= WDATA[`ACC_TRG_HI:`ACC_TRG_LO];
               `ACC_OFF_RES_UPPER: res_up_q <= WDATA;
               `ACC_OFF_RES_LOWER: res_lo_q <= WDATA;
               default:            ;
            endcase
         end
         // status flags: write one to clear, a same-cycle event wins
         if (WR && (ADDR == `ACC_OFF_STATUS))
         begin
            if (WDATA[`ACC_STS_DONE])
               CONV_DONE_FLAG <= 1'b0;
            if (WDATA[`ACC_STS_TMRA])
               TMR_A_FLAG <= 1'b0;
            if (WDATA[`ACC_STS_TMRB])
               TMR_B_FLAG <= 1'b0;
         end
         // timer flags follow their events whether selected or not
         if (TMR_A_OVERFLOW)
            TMR_A_FLAG <= 1'b1;
         if (TMR_B_OVERFLOW)
            TMR_B_FLAG <= 1'b1;
         case (state_q)
            ST_IDLE:
            begin
               SAMPLE_HOLD <= 1'b1;
               if (start)
               begin
                  go_q        <= 1'b1;
                  state_q     <= ST_CONV;
                  half_q      <= 5'h00;
                  sar_q       <= 10'h000;
                  bit_q       <= 4'h9;
                  lsb_done_q  <= 1'b0;
                  SAMPLE_HOLD <= 1'b0;
                  DAC_CODE    <= 10'h200;
               end
            end
            ST_CONV:
            begin
               if (abort)
               begin
                  {res_up_q, res_lo_q} <= justify(abort_value, just_q);
                  go_q    <= 1'b0;
                  state_q <= ST_IDLE;
               end
               else if (half_tick)
               begin
                  half_q <= half_q + 5'h01;
                  // odd half ticks close a bit; first period and a half is setup
                  if (half_q[0] && (half_q >= 5'h03) && (half_q <= 5'h15))
                  begin
                     sar_q[bit_q] <= COMPARE_HIGH;
                     if (bit_q != 4'h0)
                     begin
                        bit_q    <= bit_q - 4'h1;
                        DAC_CODE <= (sar_q | ({9'h000, COMPARE_HIGH} << bit_q)) |
                                    ({9'h000, 1'b1} << (bit_q - 4'h1));
                     end
                     else
                        lsb_done_q <= 1'b1;
                  end
                  if (half_q == (`ACC_HALF_PERIODS - 5'h01))
                  begin
                     {res_up_q, res_lo_q} <= justify(sar_q, just_q);
                     go_q           <= 1'b0;
                     CONV_DONE_FLAG <= 1'b1;
                     state_q        <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> dv/acc_analog_model.sv
// behavioural sample-and-hold with bit-decision comparator
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model
(
   input  wire logic       clk,
   input  wire logic       sample_hold,
   input  wire logic [9:0] dac_code,
   input  wire logic [9:0] level,
   output var  logic       compare_high
);
   logic [9:0] held_q = 10'h000;
   // input is frozen while converting, as the real hold capacitor is
   always @(posedge clk)
   begin
      if (sample_hold)
         held_q <= level;
   end
   assign compare_high = (dac_code <= held_q);
endmodule
`default_nettype wire

// >>> dv/acc_checker.sv
// concurrent checks on the conversion control ports
`timescale 1ns/1ps
`default_nettype none
module acc_checker
(
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic       TMR_A_OVERFLOW,
   input wire logic [9:0] DAC_CODE,
   input wire logic       SAMPLE_HOLD,
   input wire logic       ANALOG_POWER,
   input wire logic [3:0] INPUT_ROUTE,
   input wire logic [1:0] POSREF_ROUTE,
   input wire logic       TMR_A_FLAG,
   input wire logic       CONV_DONE_FLAG
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_unmapped_zero: assert property (RD && ADDR > 3'h5 |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_power_follows: assert property (WR && ADDR == 3'h0 |=> ANALOG_POWER == $past(WDATA[0]))
      else $error("power does not follow write");
   a_off_no_route: assert property (!ANALOG_POWER |-> INPUT_ROUTE == 4'h0)
      else $error("input routed while off");
   a_temp_route: assert property (WR && ADDR == 3'h0 && WDATA == 8'h75 |=> INPUT_ROUTE == 4'h5)
      else $error("temperature input not routed");
   a_posref_follows: assert property (WR && ADDR == 3'h1 |=> POSREF_ROUTE == $past(WDATA[1:0]))
      else $error("reference route wrong");
   a_msb_first: assert property ($fell(SAMPLE_HOLD) |-> DAC_CODE == 10'h200)
      else $error("first trial not msb");
   a_done_ends_conv: assert property ($rose(CONV_DONE_FLAG) |-> !$past(SAMPLE_HOLD))
      else $error("done without conversion");
   a_tmra_sets: assert property ($rose(TMR_A_OVERFLOW) |-> ##[1:3] TMR_A_FLAG)
      else $error("timer flag not set");
endmodule
bind acc_conv_control acc_checker acc_checker_inst
(
   .CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .TMR_A_OVERFLOW, .DAC_CODE, .SAMPLE_HOLD,
   .ANALOG_POWER, .INPUT_ROUTE, .POSREF_ROUTE, .TMR_A_FLAG, .CONV_DONE_FLAG
);
`default_nettype wire

// >>> dv/acc_conv_control_bench.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module acc_conv_control_bench;
   logic       CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, rc_clk = 1'b0, cmp;
   logic [2:0] ADDR = 3'h0, rc_cnt = 3'h0;
   logic [7:0] WDATA = 8'h00, RDATA;
   logic [9:0] trg = 10'h000, level = 10'h000, DAC_CODE;
   logic [3:0] INPUT_ROUTE;
   logic [1:0] POSREF_ROUTE;
   logic       SAMPLE_HOLD, ANALOG_POWER, CONV_DONE_FLAG;
   int         err_total = 0, cmp_count = 0, n;
   int         tidx[10] = '{4, 5, 0, 1, 2, 3, 6, 7, 8, 9};
   int         hc[8] = '{1, 4, 16, 0, 2, 8, 32, 0};
   logic [4:0] input_select[9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1D, 5'h1E, 5'h1F, 5'h1C};
   logic [3:0] rte[9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h0, 4'h5, 4'h6, 4'h7, 4'h0};
   always #5 CLK = ~CLK;
   // rc oscillator runs free, far slower than the system clock
   always @(posedge CLK) {rc_clk, rc_cnt} <= {rc_clk, rc_cnt} + 4'h1;
   acc_conv_control acc_conv_control_inst
   (
      .CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .COMPARE_HIGH(cmp), .RC_CONV_CLOCK(rc_clk),
      .TMR_A_OVERFLOW(trg[0]), .TMR_B_OVERFLOW(trg[1]), .TMR_C_MATCH(trg[2]),
      .COMP_OUT_SYNCED(trg[3]), .PWM_INTERRUPT(trg[6:4]), .PWM_OFFSET_MATCH(trg[9:7]),
      .DAC_CODE, .SAMPLE_HOLD, .ANALOG_POWER, .INPUT_ROUTE, .POSREF_ROUTE,
      .TMR_A_FLAG(), .TMR_B_FLAG(), .CONV_DONE_FLAG
   );
   acc_analog_model acc_analog_model_inst
   (
      .clk(CLK), .sample_hold(SAMPLE_HOLD), .dac_code(DAC_CODE), .level, .compare_high(cmp)
   );
   task automatic test_done;
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // stimulus set after a tick moves 1 ns after the edge, so sampling never races
   task automatic tick;
      @(posedge CLK);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      tick();
      WR <= 1'b0;
      tick();
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      ADDR <= a;
      RD <= 1'b1;
      tick();
      RD <= 1'b0;
      // read data stand only in the cycle after the strobe
      `CHK(RDATA, e)
      tick();
   endtask
   task automatic wait_done(input int lim);
      n = 0;
      while (CONV_DONE_FLAG !== 1'b1 && n < lim)
      begin
         tick();
         n++;
      end
      `CHK(n < lim, 1'b1)
      if (n >= lim) test_done();
   endtask
   task automatic conv(input logic [7:0] cfg, input logic [9:0] l, input int h);
      level = l;
      wr(3'h1, cfg);
      wr(3'h0, 8'h01);
      repeat (4) tick();
      wr(3'h0, 8'h03);
      rd(3'h0, 8'h03);
      wait_done(3000);
      if (h > 0) `CHK(n + 3 >= 22 * h && n + 3 <= 24 * h + 3, 1'b1)
      rd(3'h0, 8'h01);
      rd(3'h3, cfg[7] ? {6'h00, l[9:8]} : l[9:2]);
      rd(3'h4, cfg[7] ? l[7:0] : {l[1:0], 6'h00});
      rd(3'h5, 8'h01);
      wr(3'h5, 8'h01);
      rd(3'h5, 8'h00);
   endtask
   initial
   begin
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      tick();
      for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
      wr(3'h6, 8'hFF);
      rd(3'h6, 8'h00);
      wr(3'h0, 8'h02);
      rd(3'h0, 8'h00);
      `CHK(ANALOG_POWER, 1'b0)
      for (int i = 0; i < 9; i++)
      begin
         wr(3'h0, {1'b0, input_select[i], 2'b01});
         `CHK(INPUT_ROUTE, rte[i])
      end
      rd(3'h0, 8'h71);
      for (int r = 0; r < 4; r++)
      begin
         wr(3'h1, 8'(r));
         `CHK(POSREF_ROUTE, 2'(r))
      end
      for (int k = 0; k < 8; k++) conv({k[0], 3'(k), 4'h0}, 10'h2C9 ^ 10'(k * 73), hc[k]);
      conv(8'h80, 10'h3FF, 1);
      conv(8'h00, 10'h000, 1);
      level = 10'h2A5;
      wr(3'h1, 8'h60);
      wr(3'h0, 8'h03);
      repeat (270) tick();
      wr(3'h0, 8'h01);
      rd(3'h3, 8'hBF);
      rd(3'h4, 8'hC0);
      rd(3'h5, 8'h00);
      // reset in mid-conversion returns control, config and status to their cleared state
      wr(3'h0, 8'h03);
      repeat (20) tick();
      RST <= 1'b1;
      repeat (2) tick();
      RST <= 1'b0;
      tick();
      rd(3'h0, 8'h00);
      rd(3'h1, 8'h00);
      rd(3'h5, 8'h00);
      wr(3'h0, 8'h01);
      wr(3'h1, 8'h80);
      for (int c = 1; c < 12; c++)
      begin
         wr(3'h2, 8'(c << 4));
         trg <= (c > 10) ? 10'h3FF : 10'h001 << tidx[c - 1];
         repeat (40) tick();
         rd(3'h5, {5'h00, trg[1], trg[0], c < 11});
         wr(3'h5, 8'h01);
         repeat (40) tick();
         // a held level must not start another conversion
         rd(3'h5, {5'h00, trg[1], trg[0], 1'b0});
         trg <= 10'h000;
         tick();
         wr(3'h5, 8'h07);
         rd(3'h5, 8'h00);
      end
      rd(3'h2, 8'hB0);
      test_done();
   end
endmodule
`default_nettype wire
